//--- hcm_cfg.svh
/*
  Constants for the calibration, nonvolatile-program and monitor register slice.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef HCM_CFG_SVH
`define HCM_CFG_SVH
`define HCM_ADDR_CTRL 8'h1E
`define HCM_ADDR_SUPPLY 8'h21
`define HCM_ADDR_PERIOD 8'h22
`define HCM_CAL_LSB 4
`define HCM_CAL_MSB 5
`define HCM_STATUS_BIT 2
`define HCM_LAUNCH_BIT 0
`define HCM_CAL_RESET 2'h2
`define HCM_NVM_FIRST 8'h16
`define HCM_NVM_LAST 8'h1A
`define HCM_CAL0_MIN_MS 150
`define HCM_CAL1_MIN_MS 250
`define HCM_CAL2_MIN_MS 500
`define HCM_CAL3_MIN_MS 1000
`define HCM_CAL_SPAN_MS 200
`define HCM_MS_CYCLES 25000
`endif

//--- hcm_pkg.sv
/*
  Types shared by the register slice.
  Assumes the cfg header supplies numeric constants.
*/
package hcm_pkg;
  typedef enum logic [1:0] {
    HCM_IDLE = 2'b00,
    HCM_COPY = 2'b01,
    HCM_DONE = 2'b10
  } hcm_nvm_state_t;
endpackage

//--- hcm_monitor.sv
/*
  One monitor register that follows its measurement only during playback.
  Assumes the measurement input is synchronous to the clock.
*/
`timescale 1ns/100ps
module hcm_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic playing,
  input wire logic [7:0] sample,
  output logic [7:0] value
);
  logic [7:0] value_ff;
  wire [7:0] nxt_value = playing ? sample : value_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_ff <= 8'h00;
    end else begin
      value_ff <= nxt_value;
    end
  end
  assign value = value_ff;
  AST_HOLD_IDLE: assert property (@(posedge clk) disable iff (rst)
    !$past(playing) |-> value_ff == $past(value_ff)) else $error("monitor moved while idle");
  AST_TRACK: assert property (@(posedge clk) disable iff (rst)
    $past(playing) && !$past(rst) |-> value_ff == $past(sample))
    else $error("monitor missed sample");
endmodule

//--- hcm_regs.sv
/*
  Calibration-duration and nonvolatile-program control register plus two monitors.
  Assumes a synchronous register port from the serial bus front end, with a
  one-cycle write strobe and combinational read data, and an external
  nonvolatile programmer that answers a start pulse with a done pulse.
*/
`timescale 1ns/100ps
`include "hcm_cfg.svh"
module hcm_regs (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic PLAYING,
  input wire logic [7:0] SUPPLY_SAMPLE,
  input wire logic [7:0] RESONANCE_PERIOD_SAMPLE,
  input wire logic NVM_DONE,
  output logic NVM_START,
  output logic [7:0] NVM_FIRST_ADDR,
  output logic [7:0] NVM_LAST_ADDR,
  output logic [1:0] CAL_TIME_SEL,
  output logic [31:0] CAL_MIN_CYCLES,
  output logic [31:0] CAL_MAX_CYCLES
);
  logic [1:0] cal_ff;
  logic status_ff;
  logic launch_ff;
  logic start_ff;
  hcm_pkg::hcm_nvm_state_t state_ff;
  hcm_pkg::hcm_nvm_state_t nxt_state;
  logic [7:0] supply_code;
  logic [7:0] resonance_period_code;

  wire sel_ctrl = REG_ADDR == `HCM_ADDR_CTRL;
  wire sel_supply = REG_ADDR == `HCM_ADDR_SUPPLY;
  wire sel_period = REG_ADDR == `HCM_ADDR_PERIOD;
  wire wr_ctrl = REG_WR && sel_ctrl;
  wire [1:0] nxt_cal = wr_ctrl ? REG_WDATA[`HCM_CAL_MSB:`HCM_CAL_LSB] : cal_ff;
  // A launch is honoured only from idle and never after programming completed.
  wire launch_req = wr_ctrl && REG_WDATA[`HCM_LAUNCH_BIT];
  wire launch_ok = launch_req && state_ff == hcm_pkg::HCM_IDLE && !status_ff;
  wire nxt_launch = launch_ok ? 1'b1 : (nxt_state == hcm_pkg::HCM_COPY);
  wire nxt_status = status_ff || (state_ff == hcm_pkg::HCM_COPY && NVM_DONE);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      hcm_pkg::HCM_IDLE: begin
        if (launch_ok) begin
          nxt_state = hcm_pkg::HCM_COPY;
        end
      end
      hcm_pkg::HCM_COPY: begin
        if (NVM_DONE) begin
          nxt_state = hcm_pkg::HCM_DONE;
        end
      end
      hcm_pkg::HCM_DONE: begin
        nxt_state = hcm_pkg::HCM_DONE;
      end
      default: begin
        nxt_state = hcm_pkg::HCM_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cal_ff <= `HCM_CAL_RESET;
      status_ff <= 1'b0;
      launch_ff <= 1'b0;
      start_ff <= 1'b0;
      state_ff <= hcm_pkg::HCM_IDLE;
    end else begin
      cal_ff <= nxt_cal;
      status_ff <= nxt_status;
      launch_ff <= nxt_launch;
      start_ff <= launch_ok;
      state_ff <= nxt_state;
    end
  end

  hcm_monitor u_supply (
    .clk(SYS_CLK),
    .rst(RST),
    .playing(PLAYING),
    .sample(SUPPLY_SAMPLE),
    .value(supply_code)
  );
  hcm_monitor u_period (
    .clk(SYS_CLK),
    .rst(RST),
    .playing(PLAYING),
    .sample(RESONANCE_PERIOD_SAMPLE),
    .value(resonance_period_code)
  );

  // Reserved control bits are forced to zero on read.
  wire [7:0] ctrl_view = {2'b00, cal_ff, 1'b0, status_ff, 1'b0, launch_ff};
  assign REG_RDATA = sel_ctrl ? ctrl_view :
                     sel_supply ? supply_code :
                     sel_period ? resonance_period_code : 8'h00;

  // Calibration window bounds in clock cycles, selected by the duration field.
  wire [31:0] cal_min_ms = (cal_ff == 2'h0) ? `HCM_CAL0_MIN_MS :
                           (cal_ff == 2'h1) ? `HCM_CAL1_MIN_MS :
                           (cal_ff == 2'h2) ? `HCM_CAL2_MIN_MS : `HCM_CAL3_MIN_MS;
  assign CAL_MIN_CYCLES = cal_min_ms * `HCM_MS_CYCLES;
  assign CAL_MAX_CYCLES = (cal_min_ms + `HCM_CAL_SPAN_MS) * `HCM_MS_CYCLES;
  assign CAL_TIME_SEL = cal_ff;
  assign NVM_START = start_ff;
  assign NVM_FIRST_ADDR = `HCM_NVM_FIRST;
  assign NVM_LAST_ADDR = `HCM_NVM_LAST;

  // Named steps of the program-launch handshake.
  sequence s_launch;
    wr_ctrl && REG_WDATA[`HCM_LAUNCH_BIT] && state_ff == hcm_pkg::HCM_IDLE && !status_ff;
  endsequence
  sequence s_started;
    start_ff && state_ff == hcm_pkg::HCM_COPY;
  endsequence
  sequence s_refused;
    launch_req && !launch_ok;
  endsequence
  sequence s_copy_done;
    state_ff == hcm_pkg::HCM_COPY && NVM_DONE;
  endsequence

  // Duration field: reset value, write, hold and read-back.
  AST_CAL_WRITE: assert property (@(posedge SYS_CLK) disable iff (RST)
    wr_ctrl |=> cal_ff == $past(REG_WDATA[`HCM_CAL_MSB:`HCM_CAL_LSB]))
    else $error("duration not stored");

  AST_CAL_RESET: assert property (@(posedge SYS_CLK)
    RST |=> cal_ff == `HCM_CAL_RESET) else $error("duration reset wrong");

  AST_CAL_HOLD: assert property (@(posedge SYS_CLK) disable iff (RST)
    !wr_ctrl |=> cal_ff == $past(cal_ff))
    else $error("duration changed without write");

  AST_CAL_READ: assert property (@(posedge SYS_CLK) disable iff (RST)
    sel_ctrl |-> REG_RDATA[`HCM_CAL_MSB:`HCM_CAL_LSB] == cal_ff)
    else $error("duration read wrong");

  // Window bounds for each duration code.
  AST_CAL_BOUNDS0: assert property (@(posedge SYS_CLK) disable iff (RST)
    cal_ff == 2'h0 |-> CAL_MIN_CYCLES == `HCM_CAL0_MIN_MS * `HCM_MS_CYCLES &&
      CAL_MAX_CYCLES == (`HCM_CAL0_MIN_MS + `HCM_CAL_SPAN_MS) * `HCM_MS_CYCLES)
    else $error("code 0 bounds wrong");

  AST_CAL_BOUNDS1: assert property (@(posedge SYS_CLK) disable iff (RST)
    cal_ff == 2'h1 |-> CAL_MIN_CYCLES == `HCM_CAL1_MIN_MS * `HCM_MS_CYCLES &&
      CAL_MAX_CYCLES == (`HCM_CAL1_MIN_MS + `HCM_CAL_SPAN_MS) * `HCM_MS_CYCLES)
    else $error("code 1 bounds wrong");

  AST_CAL_BOUNDS2: assert property (@(posedge SYS_CLK) disable iff (RST)
    cal_ff == 2'h2 |-> CAL_MIN_CYCLES == `HCM_CAL2_MIN_MS * `HCM_MS_CYCLES &&
      CAL_MAX_CYCLES == (`HCM_CAL2_MIN_MS + `HCM_CAL_SPAN_MS) * `HCM_MS_CYCLES)
    else $error("code 2 bounds wrong");

  AST_CAL_BOUNDS: assert property (@(posedge SYS_CLK) disable iff (RST)
    cal_ff == 2'h3 |-> CAL_MIN_CYCLES == `HCM_CAL3_MIN_MS * `HCM_MS_CYCLES &&
      CAL_MAX_CYCLES == (`HCM_CAL3_MIN_MS + `HCM_CAL_SPAN_MS) * `HCM_MS_CYCLES)
    else $error("duration bounds wrong");

  // Programmed status: clear after reset, set by a finished copy, then sticky.
  AST_STATUS_SET: assert property (@(posedge SYS_CLK) disable iff (RST)
    s_copy_done |=> status_ff ##1 status_ff)
    else $error("status not set");

  AST_STATUS_RESET: assert property (@(posedge SYS_CLK)
    RST |=> !status_ff) else $error("status reset wrong");

  AST_STATUS_STICKY: assert property (@(posedge SYS_CLK) disable iff (RST)
    status_ff |=> status_ff) else $error("status dropped");

  AST_STATUS_READ: assert property (@(posedge SYS_CLK) disable iff (RST)
    sel_ctrl |-> REG_RDATA[`HCM_STATUS_BIT] == status_ff)
    else $error("status read wrong");

  // Launch handshake toward the programmer.
  AST_LAUNCH: assert property (@(posedge SYS_CLK) disable iff (RST)
    s_launch |=> s_started ##1 !start_ff) else $error("launch not started");

  AST_START_PULSE: assert property (@(posedge SYS_CLK) disable iff (RST)
    start_ff |=> !start_ff) else $error("start pulse too long");

  AST_NVM_RANGE: assert property (@(posedge SYS_CLK) disable iff (RST)
    NVM_FIRST_ADDR == `HCM_NVM_FIRST && NVM_LAST_ADDR == `HCM_NVM_LAST)
    else $error("copy range wrong");

  AST_DONE_ENDS: assert property (@(posedge SYS_CLK) disable iff (RST)
    s_copy_done |=> state_ff == hcm_pkg::HCM_DONE)
    else $error("copy did not finish");

  AST_REFUSED: assert property (@(posedge SYS_CLK) disable iff (RST)
    s_refused |=> !start_ff) else $error("refused launch started");

  AST_ONCE: assert property (@(posedge SYS_CLK) disable iff (RST)
    status_ff |-> !start_ff && state_ff != hcm_pkg::HCM_COPY) else $error("second launch");

  // Read path: reserved bits, unmapped space and monitors.
  AST_RSVD: assert property (@(posedge SYS_CLK) disable iff (RST)
    sel_ctrl |-> REG_RDATA[7:6] == 2'b00 && !REG_RDATA[3] && !REG_RDATA[1])
    else $error("reserved bits nonzero");

  AST_UNMAPPED: assert property (@(posedge SYS_CLK) disable iff (RST)
    !sel_ctrl && !sel_supply && !sel_period |-> REG_RDATA == 8'h00)
    else $error("unmapped read nonzero");

  AST_READ_SUPPLY: assert property (@(posedge SYS_CLK) disable iff (RST)
    sel_supply && $past(PLAYING) && !$past(RST) |-> REG_RDATA == $past(SUPPLY_SAMPLE))
    else $error("supply read wrong");

  AST_READ_PERIOD: assert property (@(posedge SYS_CLK) disable iff (RST)
    sel_period && !$past(PLAYING) |-> REG_RDATA == $past(resonance_period_code))
    else $error("period read wrong");

  AST_MON_NO_WRITE: assert property (@(posedge SYS_CLK) disable iff (RST)
    REG_WR && sel_supply && !PLAYING |=> supply_code == $past(supply_code))
    else $error("monitor took a write");
endmodule

//--- hcm_nvm_model.sv
/*
  Nonvolatile programmer model that answers a start pulse with a done pulse.
  Assumes the clock and start pulse come from the register slice.
*/
`timescale 1ns/100ps
module hcm_nvm_model #(parameter int DELAY = 5) (
  input wire logic clk,
  input wire logic start,
  output logic done
);
  int cnt = 0;
  initial done = 1'b0;
  // The copy takes DELAY cycles, then one done pulse follows.
  always @(posedge clk) begin
    done <= (cnt == 1);
    if (start) begin
      cnt <= DELAY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

//--- haptic_cal_otp_monitor_regs_test.sv
/*
  Self-checking bench for the register slice with a programmer model.
  Assumes the cfg header and a 25 MHz clock.
*/
`timescale 1ns/100ps
`include "hcm_cfg.svh"
module haptic_cal_otp_monitor_regs_test;
  logic clk, rst, wr, play, done, start;
  logic [7:0] addr, wdata, rdata, sup, per, fa, la;
  logic [1:0] sel;
  logic [31:0] cmin, cmax;
  int err_total = 0, cmp_count = 0, seed = 32'hbba7, es = 0, ep = 0;
  int mins[4] = '{150, 250, 500, 1000};
  hcm_regs i_dut (.SYS_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .PLAYING(play), .SUPPLY_SAMPLE(sup),
    .RESONANCE_PERIOD_SAMPLE(per), .NVM_DONE(done), .NVM_START(start),
    .NVM_FIRST_ADDR(fa), .NVM_LAST_ADDR(la), .CAL_TIME_SEL(sel),
    .CAL_MIN_CYCLES(cmin), .CAL_MAX_CYCLES(cmax));
  hcm_nvm_model i_nvm (.clk(clk), .start(start), .done(done));
  task end_sim;
    $display("Compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task wrr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) begin addr = a; wdata = d; wr = 1'b1; end
    @(negedge clk) wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) addr = a;
    #1 chk(rdata, e);
  endtask
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  initial begin
    #400000;
    err_total++;
    end_sim();
  end
  initial begin
    rst = 1; wr = 0; play = 0; addr = 0; wdata = 0; sup = 8'h5A; per = 8'hC3;
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 0;
    rd(`HCM_ADDR_CTRL, 8'h20);
    rd(`HCM_ADDR_SUPPLY, 8'h00);
    rd(`HCM_ADDR_PERIOD, 8'h00);
    rd(8'h23, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wrr(`HCM_ADDR_CTRL, 8'hCA | (c << 4));
      rd(`HCM_ADDR_CTRL, c << 4);
      chk(sel, c);
      chk(cmin, mins[c] * `HCM_MS_CYCLES);
      chk(cmax, (mins[c] + 200) * `HCM_MS_CYCLES);
    end
    wrr(`HCM_ADDR_CTRL, 8'h31);
    chk(start, 1'b1);
    chk({fa, la}, 16'h161A);
    rd(`HCM_ADDR_CTRL, 8'h31);
    for (int i = 0; i < 20 && done !== 1'b1; i++) rd(`HCM_ADDR_CTRL, 8'h31);
    rd(`HCM_ADDR_CTRL, 8'h34);
    wrr(`HCM_ADDR_CTRL, 8'h01);
    chk(start, 1'b0);
    rd(`HCM_ADDR_CTRL, 8'h04);
    wrr(`HCM_ADDR_SUPPLY, 8'hFF);
    rd(`HCM_ADDR_SUPPLY, 8'h00);
    for (int i = 0; i < 300; i++) begin
      @(negedge clk);
      #1 chk(rdata, (addr == `HCM_ADDR_SUPPLY) ? es : ep);
      play = $random(seed);
      sup = $random(seed);
      per = $random(seed);
      addr = i[0] ? `HCM_ADDR_SUPPLY : `HCM_ADDR_PERIOD;
      @(posedge clk);
      if (play) begin
        es = sup;
        ep = per;
      end
    end
    @(negedge clk) begin play = 0; rst = 1; end
    @(negedge clk) rst = 0;
    rd(`HCM_ADDR_CTRL, 8'h20);
    rd(`HCM_ADDR_SUPPLY, 8'h00);
    end_sim();
  end
endmodule
